// File: verilog/stream_port_pkg.sv
// Constants and carrier types shared by the debug stream port
package stream_port_pkg;

	// Core clock and derived timing
	localparam int CLK_HZ             = 20_000_000;                          // Core clock rate
	localparam int CLK_PER_US         = CLK_HZ / 1_000_000;                  // Cycles per microsecond
	localparam int BIT_TIME_NS        = 1000;                                // One-wire bit period
	localparam int BIT_CYCLES         = (BIT_TIME_NS * CLK_PER_US + 999) / 1000; // Rounded up
	localparam logic [7:0] BIT_LAST   = 8'(BIT_CYCLES - 1);                  // Last cycle of a bit
	localparam int EVENT_PULSE_US     = 1600;                                // Event low pulse, 1.6 ms
	localparam int EVENT_PULSE_CYCLES = EVENT_PULSE_US * CLK_PER_US;         // Rounded down

	// Frame layout
	localparam logic [7:0] SYNC_BYTE  = 8'hAA;                               // Opens every frame
	localparam logic [3:0] LAST_BYTE  = 4'h8;                                // Sync plus eight data bytes
	localparam logic [2:0] LAST_BIT   = 3'h7;                                // Eight bits per byte
	localparam logic [3:0] I2C_BITS   = 4'h8;                                // Bits per I2C byte
	localparam logic [6:0] I2C_ADDR   = 7'h44;                               // Fixed target address

	// System flag byte field positions
	localparam int FLAG_POLARITY  = 6;                                       // Output active high
	localparam int FLAG_HALT      = 5;                                       // Filter halted
	localparam int FLAG_LOWPOWER  = 4;                                       // Low power active
	localparam int FLAG_TUNING    = 3;                                       // Auto tuning busy
	localparam int FLAG_NOISE     = 2;                                       // Noise found
	localparam int FLAG_ZOOM      = 1;                                       // Zoom active

	// Detection debounce lengths, channel 0 proximity, channel 1 touch
	localparam logic [2:0] PROX_CONSEC  = 3'h6;
	localparam logic [2:0] TOUCH_CONSEC = 3'h2;

	// Proximity thresholds in counts, by selection code
	localparam logic [15:0] PROX_THR_0 = 16'h0004;
	localparam logic [15:0] PROX_THR_1 = 16'h0002;
	localparam logic [15:0] PROX_THR_2 = 16'h0008;
	localparam logic [15:0] PROX_THR_3 = 16'h0010;

	// Touch thresholds in 1/256 of the long term average
	localparam logic [7:0] TOUCH_FRAC_0 = 8'h48;
	localparam logic [7:0] TOUCH_FRAC_1 = 8'h04;
	localparam logic [7:0] TOUCH_FRAC_2 = 8'h08;
	localparam logic [7:0] TOUCH_FRAC_3 = 8'h18;
	localparam logic [7:0] TOUCH_FRAC_4 = 8'h30;
	localparam logic [7:0] TOUCH_FRAC_5 = 8'h60;
	localparam logic [7:0] TOUCH_FRAC_6 = 8'h80;
	localparam logic [7:0] TOUCH_FRAC_7 = 8'hA0;

	// Static configuration options
	typedef struct packed {
		logic       stream_enable_option;                                    // 1 enables streaming
		logic       streamProtocol;                                          // 0 one-wire, 1 I2C
		logic       eventMode;                                               // Event pulses on change, one-wire mode only
		logic       activeHigh;                                              // Output polarity
		logic [1:0] proxThrSel;                                              // Proximity threshold code
		logic [2:0] touchThrSel;                                             // Touch threshold code
	} cfg_t;

	// Per sensing cycle measurements and flags
	typedef struct packed {
		logic [15:0] counts;                                                 // Charge transfer counts
		logic [15:0] long_term_average;                                      // Baseline
		logic [5:0]  multiplier;                                             // Tuning multiplier
		logic [7:0]  compensation;                                           // Tuning compensation
		logic        auto_tuning;                                            // Tuning busy
		logic        filterHalt;                                             // Baseline halted
		logic        low_power_flag;                                         // Low power active
		logic        noiseFound;                                             // Noise detected
		logic        zoomActive;                                             // Zoom active
	} sense_t;

	// Eight data bytes in send order, first byte in the top bits
	typedef struct packed {
		logic [7:0] countsHi;
		logic [7:0] countsLo;
		logic [7:0] averageHi;
		logic [7:0] averageLo;
		logic [7:0] sysFlags;
		logic [7:0] detect;
		logic [7:0] compensation;
		logic [7:0] counter;
	} frame_t;

	// One-wire transmitter states
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_START = 2'b01,
		TX_DATA  = 2'b10,
		TX_STOP  = 2'b11
	} tx_state_t;

	// I2C target states
	typedef enum logic [2:0] {
		I2C_IDLE = 3'b000,
		I2C_HEAD = 3'b001,
		I2C_ACK  = 3'b010,
		I2C_SEND = 3'b011,
		I2C_WAIT = 3'b100
	} i2c_state_t;

endpackage : stream_port_pkg

// File: verilog/frame_store.sv
// Snapshot memory for the eight data bytes of one frame
`timescale 1ns/1ps
module frame_store
	import stream_port_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    arst_n,
	input  wire logic                    load,
	input  wire stream_port_pkg::frame_t frameIn,
	input  wire logic [2:0]              rdIndex,
	output logic [7:0]                   rdData
);
	logic [63:0] bytes;                      // Stored frame, byte 0 on top
	wire  [7:0]  selByte;                    // Byte picked by the index

	assign selByte = bytes[63 - 8 * rdIndex -: 8];

	// Whole frame written in one edge, registered read
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bytes  <= 64'h0000_0000_0000_0000;
			rdData <= 8'h00;
		end else begin
			if (load) begin
				bytes <= frameIn;
			end
			rdData <= selByte;
		end
	end
endmodule : frame_store

// File: verilog/sensor_debug_stream_port.sv
// Debug stream port: detection, frame build, one-wire sender, event pulse, I2C target
`timescale 1ns/1ps
module sensor_debug_stream_port
	import stream_port_pkg::*;
#(
	parameter int EVENT_CYCLES = stream_port_pkg::EVENT_PULSE_CYCLES      // Event pulse length
)(
	input  wire logic                    core_clk,
	input  wire logic                    arst_n,
	input  wire stream_port_pkg::cfg_t   cfg,
	input  wire stream_port_pkg::sense_t sense,
	input  wire logic                    sampleDone,
	input  wire logic                    detectPinIn,
	output logic                         detectPinOut,
	output logic                         detectPinOe,
	input  wire logic                    event_output_pinIn,
	output logic                         event_output_pinOut,
	output logic                         event_output_pinOe,
	input  wire logic                    sclPin,
	input  wire logic                    sdaPinIn,
	output logic                         sdaPinOut,
	output logic                         sdaPinOe,
	output logic                         proximity,
	output logic                         touch,
	output logic                         streamBusy
);
	// Mode decode
	wire oneWireMode = cfg.stream_enable_option & ~cfg.streamProtocol;
	wire i2cMode     = cfg.stream_enable_option & cfg.streamProtocol;
	wire unusedPins  = detectPinIn ^ event_output_pinIn;                 // Pin readback unused

	// Detection thresholds
	logic [15:0] proxThr;                                                // Selected proximity threshold
	logic [7:0]  touchFrac;                                              // Selected touch fraction
	wire  [23:0] touchProd = 24'(sense.long_term_average) * 24'(touchFrac); // Average times fraction
	wire  [15:0] touchThr  = touchProd[23:8];                            // Touch threshold in counts
	wire         below     = sense.counts < sense.long_term_average;     // Counts under baseline
	wire  [15:0] deficit   = below ? 16'(sense.long_term_average - sense.counts) : 16'h0000;

	always_comb begin
		case (cfg.proxThrSel)
			2'b00:   proxThr = PROX_THR_0;
			2'b01:   proxThr = PROX_THR_1;
			2'b10:   proxThr = PROX_THR_2;
			default: proxThr = PROX_THR_3;
		endcase
		case (cfg.touchThrSel)
			3'b000:  touchFrac = TOUCH_FRAC_0;
			3'b001:  touchFrac = TOUCH_FRAC_1;
			3'b010:  touchFrac = TOUCH_FRAC_2;
			3'b011:  touchFrac = TOUCH_FRAC_3;
			3'b100:  touchFrac = TOUCH_FRAC_4;
			3'b101:  touchFrac = TOUCH_FRAC_5;
			3'b110:  touchFrac = TOUCH_FRAC_6;
			default: touchFrac = TOUCH_FRAC_7;
		endcase
	end

	// Debounced detectors, channel 0 proximity, channel 1 touch
	logic [1:0] detState;                                                // Current states
	wire  [1:0] next_detState;                                           // States after this sample
	wire  [1:0] over = {deficit > touchThr, deficit > proxThr};          // Raw divergence

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_det
			logic [2:0] run;                                             // Consecutive disagreeing samples
			wire  [2:0] need = (ch == 0) ? PROX_CONSEC : TOUCH_CONSEC;
			wire        differ = over[ch] != detState[ch];
			wire        flip   = differ & (run == 3'(need - 3'h1));
			assign next_detState[ch] = !sampleDone ? detState[ch] :
				sense.auto_tuning ? 1'b0 : (flip ? over[ch] : detState[ch]);

			// Count disagreeing samples, reset on tuning, agreement or flip
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					run <= 3'h0;
				end else if (sampleDone) begin
					if (sense.auto_tuning || !differ || flip) begin
						run <= 3'h0;
					end else begin
						run <= run + 3'h1;
					end
				end
			end
		end
	endgenerate

	// Frame snapshot built from this cycle's values
	logic [7:0] frameCount;                                              // Frame counter byte
	frame_t     frameNow;
	wire        stateChange = sampleDone & (next_detState != detState);

	always_comb begin
		frameNow              = '0;
		frameNow.countsHi     = sense.counts[15:8];
		frameNow.countsLo     = sense.counts[7:0];
		frameNow.averageHi    = sense.long_term_average[15:8];
		frameNow.averageLo    = sense.long_term_average[7:0];
		frameNow.sysFlags[FLAG_POLARITY] = cfg.activeHigh;
		frameNow.sysFlags[FLAG_HALT]     = sense.filterHalt;
		frameNow.sysFlags[FLAG_LOWPOWER] = sense.low_power_flag;
		frameNow.sysFlags[FLAG_TUNING]   = sense.auto_tuning;
		frameNow.sysFlags[FLAG_NOISE]    = sense.noiseFound;
		frameNow.sysFlags[FLAG_ZOOM]     = sense.zoomActive;
		frameNow.detect       = {next_detState[1], next_detState[0], sense.multiplier};
		frameNow.compensation = sense.compensation;
		frameNow.counter      = frameCount;
	end

	// Memory read port, shared by the two senders
	logic [3:0] byteIdx;                                                 // One-wire byte, 0 is sync
	logic [3:0] i2cPtr;                                                  // I2C byte, 0 is sync
	logic [7:0] rdData;
	wire  [3:0] curIdx  = i2cMode ? i2cPtr : byteIdx;
	wire  [3:0] memIdx  = curIdx - 4'h1;
	wire  [7:0] byteOut = (curIdx == 4'h0) ? SYNC_BYTE : rdData;

	frame_store u_store (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.load     (sampleDone),
		.frameIn  (frameNow),
		.rdIndex  (memIdx[2:0]),
		.rdData   (rdData)
	);

	// Detector state and frame counter
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			detState   <= 2'b00;
			frameCount <= 8'h00;
		end else begin
			detState <= next_detState;
			if (sampleDone) begin
				frameCount <= frameCount + 8'h01;
			end
		end
	end

	// One-wire sender
	tx_state_t  txState;
	logic [7:0] bitTimer;                                                // Cycles within a bit
	logic [2:0] bitIdx;                                                  // Data bit number
	logic [7:0] txShift;                                                 // Byte being shifted
	logic       pending;                                                 // Frame waiting to go
	wire        bitEnd  = bitTimer == BIT_LAST;
	wire        txStart = (txState == TX_IDLE) & pending & oneWireMode;
	wire        txLow   = (txState == TX_START) | ((txState == TX_DATA) & ~txShift[0]);

	// New frame sets pending; the set wins over a same-cycle start
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pending <= 1'b0;
		end else begin
			pending <= (sampleDone & oneWireMode) | (pending & ~txStart);
		end
	end

	// Bit and byte sequencing
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			txState  <= TX_IDLE;
			bitTimer <= 8'h00;
			bitIdx   <= 3'h0;
			byteIdx  <= 4'h0;
			txShift  <= 8'h00;
		end else begin
			bitTimer <= (txState == TX_IDLE || bitEnd) ? 8'h00 : bitTimer + 8'h01;
			case (txState)
				TX_IDLE: begin
					if (txStart) begin
						byteIdx <= 4'h0;
						txState <= TX_START;
					end
				end
				TX_START: begin
					if (bitEnd) begin
						txShift <= byteOut;
						bitIdx  <= 3'h0;
						txState <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (bitEnd) begin
						txShift <= {1'b0, txShift[7:1]};
						bitIdx  <= bitIdx + 3'h1;
						if (bitIdx == LAST_BIT) begin
							txState <= TX_STOP;
						end
					end
				end
				TX_STOP: begin
					if (bitEnd) begin
						if (byteIdx == LAST_BYTE) begin
							txState <= TX_IDLE;
						end else begin
							byteIdx <= byteIdx + 4'h1;
							txState <= TX_START;
						end
					end
				end
				default: txState <= TX_IDLE;
			endcase
		end
	end

	// Event pulse timer
	logic [15:0] evTimer;
	wire         evFire = stateChange & oneWireMode & cfg.eventMode;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			evTimer <= 16'h0000;
		end else if (evFire) begin
			evTimer <= 16'(EVENT_CYCLES);
		end else if (evTimer != 16'h0000) begin
			evTimer <= evTimer - 16'h0001;
		end
	end

	// I2C pin synchronisers and edge detect
	logic [2:0] sclSync;                                                 // Two stages plus history
	logic [2:0] sdaSync;
	wire        sclRise  = sclSync[1] & ~sclSync[2];
	wire        sclFall  = ~sclSync[1] & sclSync[2];
	wire        busStart = sclSync[1] & sclSync[2] & sdaSync[2] & ~sdaSync[1];
	wire        busStop  = sclSync[1] & sclSync[2] & ~sdaSync[2] & sdaSync[1];

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclSync <= 3'h7;
			sdaSync <= 3'h7;
		end else begin
			sclSync <= {sclSync[1:0], sclPin};
			sdaSync <= {sdaSync[1:0], sdaPinIn};
		end
	end

	// I2C read-only target
	i2c_state_t i2cState;
	logic [7:0] i2cShift;                                                // Address in, data out
	logic [3:0] i2cBits;
	logic       sdaDrive;                                                // Pull SDA low

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			i2cState <= I2C_IDLE;
			i2cShift <= 8'h00;
			i2cBits  <= 4'h0;
			i2cPtr   <= 4'h0;
			sdaDrive <= 1'b0;
		end else if (busStop || !i2cMode) begin
			i2cState <= I2C_IDLE;
			sdaDrive <= 1'b0;
		end else if (busStart) begin
			i2cState <= I2C_HEAD;
			i2cBits  <= 4'h0;
			i2cPtr   <= 4'h0;
			sdaDrive <= 1'b0;
		end else begin
			case (i2cState)
				I2C_HEAD: begin
					if (sclRise) begin
						i2cShift <= {i2cShift[6:0], sdaSync[1]};
						i2cBits  <= i2cBits + 4'h1;
					end else if (sclFall && i2cBits == I2C_BITS) begin
						if (i2cShift[7:1] == I2C_ADDR && i2cShift[0]) begin
							sdaDrive <= 1'b1;
							i2cState <= I2C_ACK;
						end else begin
							i2cState <= I2C_IDLE;
						end
					end
				end
				I2C_ACK: begin
					if (sclFall) begin
						sdaDrive <= ~byteOut[7];
						i2cShift <= {byteOut[6:0], 1'b0};
						i2cBits  <= 4'h1;
						i2cState <= I2C_SEND;
					end
				end
				I2C_SEND: begin
					if (sclFall) begin
						if (i2cBits == I2C_BITS) begin
							sdaDrive <= 1'b0;
							i2cState <= I2C_WAIT;
						end else begin
							sdaDrive <= ~i2cShift[7];
							i2cShift <= {i2cShift[6:0], 1'b0};
							i2cBits  <= i2cBits + 4'h1;
						end
					end
				end
				I2C_WAIT: begin
					if (sclRise) begin
						if (!sdaSync[1]) begin
							i2cPtr   <= (i2cPtr == LAST_BYTE) ? 4'h0 : i2cPtr + 4'h1;
							i2cState <= I2C_ACK;
						end else begin
							i2cState <= I2C_IDLE;
						end
					end
				end
				default: i2cState <= I2C_IDLE;
			endcase
		end
	end

	// Registered pin and status outputs
	wire active = detState[0] | detState[1];

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			detectPinOut        <= 1'b0;
			detectPinOe         <= 1'b0;
			event_output_pinOut <= 1'b0;
			event_output_pinOe  <= 1'b0;
			sdaPinOut           <= 1'b0;
			sdaPinOe            <= 1'b0;
			proximity           <= 1'b0;
			touch               <= 1'b0;
			streamBusy          <= 1'b0;
		end else begin
			if (oneWireMode) begin
				detectPinOut <= 1'b0;
				detectPinOe  <= txLow;
			end else if (i2cMode) begin
				detectPinOut <= 1'b0;
				detectPinOe  <= 1'b0;
			end else begin
				detectPinOut <= cfg.activeHigh & active;
				detectPinOe  <= cfg.activeHigh | active;
			end
			event_output_pinOut <= unusedPins & 1'b0;
			event_output_pinOe  <= evTimer != 16'h0000;
			sdaPinOut           <= 1'b0;
			sdaPinOe            <= sdaDrive;
			proximity           <= next_detState[0];
			touch               <= next_detState[1];
			streamBusy          <= txState != TX_IDLE;
		end
	end
endmodule : sensor_debug_stream_port

// File: sim/sensor_port_props.sv
// Checker for the debug stream port pins and detector outputs
`timescale 1ns/1ps
module sensor_port_props
	import stream_port_pkg::*;
#(
	parameter int EVENT_CYCLES = 40
)(
	input  wire logic                    core_clk,
	input  wire logic                    arst_n,
	input  wire stream_port_pkg::cfg_t   cfg,
	input  wire stream_port_pkg::sense_t sense,
	input  wire logic                    sampleDone,
	input  wire logic                    detectPinOe,
	input  wire logic                    detectPinOut,
	input  wire logic                    event_output_pinOe,
	input  wire logic                    sdaPinOe,
	input  wire logic                    proximity,
	input  wire logic                    touch,
	input  wire logic                    streamBusy
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic lineLow;                       // Wire pulled low
	logic oneWire;                       // One-wire streaming chosen
	logic i2cOn;                         // I2C streaming chosen
	int   lowRun;                        // Cycles of current low run
	int   evRun;                         // Cycles of current event pulse
	assign lineLow = detectPinOe && !detectPinOut;
	assign oneWire = cfg.stream_enable_option && !cfg.streamProtocol;
	assign i2cOn   = cfg.stream_enable_option && cfg.streamProtocol;
	// Run lengths of the low line and the event pulse
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			lowRun <= 0;
			evRun  <= 0;
		end else begin
			lowRun <= lineLow ? lowRun + 1 : 0;
			evRun  <= event_output_pinOe ? evRun + 1 : 0;
		end
	end
	// Start bit low, then start plus first sync bit span two bits
	sequence startLow;
		##[0:1] lineLow [*8];
	endsequence
	sequence syncLead;
		##[1:45] ($rose(!lineLow) && lowRun == 2 * BIT_CYCLES);
	endsequence
	start_bit_a: assert property ($rose(streamBusy) |-> startLow)
		else $error("start bit missing");
	sync_lead_a: assert property ($rose(streamBusy) |-> syncLead)
		else $error("sync lead wrong");
	idle_release_a: assert property (oneWire && $past(oneWire) && !streamBusy |-> !detectPinOe)
		else $error("line held between frames");
	stream_off_a: assert property (!oneWire [*4] |-> !streamBusy)
		else $error("frame while not streaming");
	i2c_pin_a: assert property (i2cOn && $past(i2cOn) |-> !detectPinOe && !streamBusy)
		else $error("detect pin used in I2C mode");
	sda_idle_a: assert property (!i2cOn && $past(!i2cOn) |-> !sdaPinOe)
		else $error("SDA driven outside I2C");
	tune_block_a: assert property (sampleDone && sense.auto_tuning |=> !proximity && !touch)
		else $error("detection during tuning");
	det_timing_a: assert property ($rose(proximity) || $rose(touch) |-> $past(sampleDone))
		else $error("detector moved without sample");
	event_cause_a: assert property (oneWire && cfg.eventMode && ($changed(proximity) || $changed(touch))
		|=> event_output_pinOe)
		else $error("no event pulse on change");
	event_len_a: assert property ($fell(event_output_pinOe) |-> evRun == EVENT_CYCLES)
		else $error("event pulse length wrong");
	event_mode_a: assert property ($rose(event_output_pinOe) |-> $past(cfg.eventMode))
		else $error("event pulse outside event mode");
endmodule : sensor_port_props

// File: sim/host_capture.sv
// Host model that decodes the one-wire debug stream
`timescale 1ns/1ps
module host_capture (
	input  wire logic       core_clk,
	input  wire logic       line,
	output logic [7:0]      rxByte,
	output logic            rxStrobe,
	output logic            rxStopOk
);
	int n;                               // Low span of start plus first sync bit
	int bitT;                            // Recovered bit period
	// Measure timing on the sync byte, then sample mid-bit
	initial begin
		rxStrobe = 0;
		rxByte = 8'h00;
		rxStopOk = 0;
		forever begin
			@(posedge core_clk iff !line);
			n = 0;
			while (!line) begin
				@(posedge core_clk);
				n++;
			end
			bitT = n / 2;
			rxByte = 8'h00;
			repeat (bitT / 2) @(posedge core_clk);
			for (int i = 0; i < 9; i++) begin
				if (i > 0) begin
					@(posedge core_clk iff !line);
					repeat (bitT + bitT / 2) @(posedge core_clk);
				end
				for (int b = (i == 0) ? 1 : 0; b < 8; b++) begin
					rxByte[b] = line;
					repeat (bitT) @(posedge core_clk);
				end
				rxStopOk = line;
				rxStrobe = 1;
				@(posedge core_clk);
				rxStrobe = 0;
			end
		end
	end
endmodule : host_capture

// File: sim/tb_top.sv
// Self-checking bench for the debug stream port
`timescale 1ns/1ps
module tb_top
	import stream_port_pkg::*;
;
	logic core_clk = 0;
	logic arst_n = 0;
	cfg_t cfg;
	sense_t sense;
	logic sampleDone = 0;
	logic detectPinOut, detectPinOe, event_output_pinOut, event_output_pinOe;
	logic sdaPinOut, sdaPinOe, proximity, touch, streamBusy, line;
	logic scl = 1, sdaM = 1;              // I2C master drive, released high
	logic [17:0] rxI2c;                   // Bits seen by the I2C master
	logic [7:0] rxByte;
	logic rxStrobe, rxStopOk;
	logic [31:0] rnd = 32'h569c_1523;     // Random source state
	int mismatches = 0;
	int check_count = 0;
	int expEv = 0, gotEv = 0, frameCnt = 0;
	int pSt = 0, pRun = 0, tSt = 0, tRun = 0; // Detector model
	int pTab[4] = '{PROX_THR_0, PROX_THR_1, PROX_THR_2, PROX_THR_3};
	int tTab[8] = '{TOUCH_FRAC_0, TOUCH_FRAC_1, TOUCH_FRAC_2, TOUCH_FRAC_3,
		TOUCH_FRAC_4, TOUCH_FRAC_5, TOUCH_FRAC_6, TOUCH_FRAC_7};
	string pat = "11111121111113111111000000"; // 0 none, 1 big, 2 at threshold, 3 tuning
	logic [7:0] rxQ[$];
	logic okQ[$];
	assign line = !(detectPinOe && !detectPinOut); // Pull-up on the wire
	wire sda = sdaM && !(sdaPinOe && !sdaPinOut); // Pull-up on SDA
	wire hostLine = line || !(cfg.stream_enable_option && !cfg.streamProtocol); // Host listens only to a one-wire stream
	always #25 core_clk = ~core_clk;
	sensor_debug_stream_port #(.EVENT_CYCLES(40)) u_sensor_debug_stream_port (.core_clk, .arst_n, .cfg,
		.sense, .sampleDone, .detectPinIn(line), .detectPinOut, .detectPinOe,
		.event_output_pinIn(!event_output_pinOe), .event_output_pinOut, .event_output_pinOe,
		.sclPin(scl), .sdaPinIn(sda), .sdaPinOut, .sdaPinOe, .proximity, .touch, .streamBusy);
	host_capture u_host_capture (.core_clk, .line(hostLine), .rxByte, .rxStrobe, .rxStopOk);
	// Collect decoded bytes and event pulses
	always @(negedge core_clk) if (rxStrobe) begin
		rxQ.push_back(rxByte);
		okQ.push_back(rxStopOk);
	end
	always @(posedge (event_output_pinOe && !event_output_pinOut)) gotEv++;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Debounce model: a run of samples disagreeing with the state flips it
	task automatic upd(input bit tun, input bit dv, input int len, ref int st, ref int run);
		run = (tun || int'(dv) == st) ? 0 : run + 1;
		st = tun ? 0 : (run == len) ? int'(dv) : st;
		run = (run == len) ? 0 : run;
	endtask : upd
	// One sensing cycle, then detector and frame compares, expected event pulses counted
	task automatic sample(input int kind, input int k);
		int avg, dfc, pThr, tThr, oldP, oldT, n;
		logic [7:0] exp[9];
		logic [7:0] got;
		logic [1:0] expPin;
		logic oneWire, act;
		rnd = lfsr(rnd);
		avg = 1024 + int'(rnd[7:0]);
		pThr = pTab[k % 4];
		tThr = (avg * tTab[k % 8]) >> 8;
		dfc = kind == 0 ? 0 : kind == 2 ? pThr : avg - avg / 4;
		sense = sense_t'({rnd, rnd[18:0]});
		sense.counts = 16'(avg - dfc);
		sense.long_term_average = 16'(avg);
		sense.auto_tuning = kind == 3;
		cfg.proxThrSel = 2'(k);
		cfg.touchThrSel = 3'(k);
		cfg.eventMode = k < 16;
		cfg.activeHigh = rnd[31];
		oneWire = cfg.stream_enable_option && !cfg.streamProtocol;
		oldP = pSt;
		oldT = tSt;
		upd(kind == 3, dfc > pThr, 6, pSt, pRun);
		upd(kind == 3, dfc > tThr, 2, tSt, tRun);
		exp = '{SYNC_BYTE, sense.counts[15:8], sense.counts[7:0], sense.long_term_average[15:8],
			sense.long_term_average[7:0], {1'b0, cfg.activeHigh, sense.filterHalt, sense.low_power_flag,
			sense.auto_tuning, sense.noiseFound, sense.zoomActive, 1'b0},
			{tSt[0], pSt[0], sense.multiplier}, sense.compensation, 8'(frameCnt)};
		act = (pSt | tSt) != 0;
		sampleDone = 1;
		@(negedge core_clk);
		sampleDone = 0;
		@(negedge core_clk);
		check("proximity", 16'(pSt), 16'(proximity));
		check("touch", 16'(tSt), 16'(touch));
		expPin = cfg.stream_enable_option ? 2'b00 : {cfg.activeHigh | act, cfg.activeHigh & act};
		if (!oneWire) check("detect pin", 16'(expPin), 16'({detectPinOe, detectPinOut}));
		expEv += int'(oneWire && cfg.eventMode && (oldP != pSt || oldT != tSt));
		for (n = 0; n < 2000 && (n < 10 || streamBusy !== 1'b0); n++)
			@(negedge core_clk);
		check("frame end", 16'h0000, 16'(streamBusy));
		check("byte count", oneWire ? 16'h0009 : 16'h0000, 16'(rxQ.size()));
		for (n = 0; rxQ.size() > 0; n++) begin
			got = rxQ.pop_front();
			check("stop bit", 16'h0001, 16'(okQ.pop_front()));
			check("frame byte", 16'(exp[n % 9]), 16'(got));
		end
		frameCnt++;
	endtask : sample
	// I2C master: START, address and direction, ten clocks ending in NACK, STOP
	task automatic i2c_xfer(input logic rw, output logic [17:0] rx);
		logic [17:0] out;
		out = {I2C_ADDR, rw, 10'h3FF};
		sdaM = 0;
		repeat (8) @(negedge core_clk);
		for (int i = 17; i >= 0; i--) begin
			scl = 0;
			repeat (4) @(negedge core_clk);
			sdaM = out[i];
			repeat (4) @(negedge core_clk);
			scl = 1;
			repeat (8) @(negedge core_clk);
			rx[i] = sda;
		end
		scl = 0;
		repeat (4) @(negedge core_clk);
		sdaM = 0;
		repeat (4) @(negedge core_clk);
		scl = 1;
		repeat (8) @(negedge core_clk);
		sdaM = 1;
		repeat (8) @(negedge core_clk);
	endtask : i2c_xfer
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	// Main sequence: one-wire stream, disabled, then I2C mode
	initial begin
		cfg = '0;
		cfg.stream_enable_option = 1;
		sense = '0;
		repeat (2) @(negedge core_clk);
		arst_n = 1;
		for (int k = 0; k < 26; k++)
			sample(int'(pat[k]) - 48, k);
		cfg.stream_enable_option = 0;
		sample(1, 26);
		sample(1, 27);
		cfg.stream_enable_option = 1;
		cfg.streamProtocol = 1;
		sample(1, 28);
		i2c_xfer(1'b1, rxI2c);
		check("i2c ack", 16'h0000, 16'(rxI2c[9]));
		check("i2c data", 16'(SYNC_BYTE), 16'(rxI2c[8:1]));
		i2c_xfer(1'b0, rxI2c);
		check("i2c write ack", 16'h0001, 16'(rxI2c[9]));
		check("event pulses", 16'(expEv), 16'(gotEv));
		stop_test();
	end
	// Watchdog against a hang
	initial begin
		#3_000_000;
		mismatches++;
		stop_test();
	end
endmodule : tb_top
bind sensor_debug_stream_port sensor_port_props #(.EVENT_CYCLES(EVENT_CYCLES)) u_sensor_port_props (
	.core_clk, .arst_n, .cfg, .sense, .sampleDone, .detectPinOe, .detectPinOut,
	.event_output_pinOe, .sdaPinOe, .proximity, .touch, .streamBusy);
